// File: rtl/ciex_pkg.sv
package ciex_pkg;
    // vectors
    localparam logic [7:0] VEC_DEBUG = 8'h01;
    localparam logic [7:0] VEC_NMI = 8'h02;
    localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
    localparam logic [7:0] VEC_OVERFLOW = 8'h04;
    localparam logic [7:0] VEC_INVALID_OP = 8'h06;
    localparam logic [7:0] VEC_DOUBLE_FAULT = 8'h08;
    localparam logic [7:0] VEC_FIRST_USER = 8'h20;
    // flag and config bit positions
    localparam int FLAG_TRACE_BIT = 8;
    localparam int FLAG_IE_BIT = 9;
    localparam int CONFIG_CONTROL_7_NMI_EN_BIT = 2;
    localparam logic [7:0] CONFIG_CONTROL_7_INDEX = 8'hEB;
    // handler table base, limit and config register reset
    localparam logic [31:0] TABLE_BASE_RST = 32'h0000_0000;
    localparam logic [15:0] TABLE_LIMIT_RST = 16'h03FF;
    localparam logic [31:0] CONFIG_CONTROL_7_RST = 32'h0000_0000;
    // table entry sizes in bytes
    localparam logic [31:0] ENTRY_REAL_BYTES = 32'h0000_0004;
    localparam logic [31:0] ENTRY_PROT_BYTES = 32'h0000_0008;
    // exception classes
    typedef enum logic [1:0] {CIEX_TRAP, CIEX_FAULT, CIEX_ABORT, CIEX_MASKABLE_IRQ} ciex_class_t;
    // register offsets
    localparam logic [7:0] REG_CONFIG_CONTROL_7 = CONFIG_CONTROL_7_INDEX;
    localparam logic [7:0] REG_TBL_BASE = 8'h00;
    localparam logic [7:0] REG_TBL_LIMIT = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_LAST_VEC = 8'h0C;
endpackage : ciex_pkg

// File: rtl/ciex_unit.sv
// Behaviour
// - nmi always uses vector 2, supplied internally, no acknowledge cycle
// - smi beats nmi, nmi beats maskable interrupt
// - nmi blocked until return; one edge latched meanwhile, served after return
// - halt inside nmi handler wakes on reset, unmasked irq or smi only
// - maskable irq accepted only while flags bit 9 is one
// - maskable irq taken at instruction boundary or string move point
// - maskable irq runs acknowledge cycle; controller returns 8-bit vector
// - hardware interrupts enter after instruction completes, return to next
// - traps reported after causing instruction: soft int, step, data break
// - soft interrupt handler runs regardless of interrupt enable flag
// - one-byte breakpoint instruction raises vector 3
// - trace flag bit 8 raises vector 1 after every instruction
// - faults reported before completion; saved pointer addresses faulting instr
// - data break and single step debug are traps, others faults
// - double fault vector 8 is the only abort, not restartable
// - handler entry pushes pointer and flags plus optional error code
// - illegal opcodes raise vector 6
// - nmi handling enabled by config register EBh bit 2
// - table indexed by vector; 4-byte entries real, 8-byte protected
// - after reset table base 0h and limit 3FFh
// - interrupt gate clears interrupt enable; trap gate leaves it (here only status bit 4 records it; flags pass unchanged)
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ciex_unit (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // interrupt pins
    input wire logic nmi_i,
    input wire logic maskable_irq_i,
    input wire logic sysmgmt_irq_n_i,
    // acknowledge cycle with external controller
    output logic ack_cycle_o,
    input wire logic ack_valid_i,
    input wire logic [7:0] ack_vector_i,
    // core pipeline events
    input wire logic instr_boundary_i,
    input wire logic string_point_i,
    input wire logic [31:0] instr_ptr_i,
    input wire logic [31:0] next_ptr_i,
    input wire logic [31:0] flags_register_i,
    input wire logic protected_mode_i,
    input wire logic halt_i,
    input wire logic return_from_interrupt_i,
    input wire logic soft_interrupt_instr_i,
    input wire logic breakpoint_instr_i,
    input wire logic [7:0] soft_vector_i,
    input wire logic data_break_i,
    input wire logic instr_break_i,
    input wire logic illegal_op_i,
    input wire logic fault_i,
    input wire logic [7:0] fault_vector_i,
    input wire logic double_fault_i,
    input wire logic gate_is_maskable_irq_i,
    input wire logic [15:0] error_code_i,
    input wire logic error_code_valid_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // dispatch to core
    output logic entry_o,
    output logic [7:0] entry_vector_o,
    output ciex_pkg::ciex_class_t entry_class_o,
    output logic [31:0] entry_addr_o,
    output logic [31:0] push_ptr_o,
    output logic [31:0] push_flags_o,
    output logic [15:0] push_error_o,
    output logic push_error_valid_o,
    output logic sysmgmt_entry_o,
    output logic halted_o,
    output logic in_nmi_o
);
    import ciex_pkg::*;

    // pin synchronisers: three stages, change accepted when stages two and three agree
    logic [2:0] nmi_sync_r;
    logic [2:0] irq_sync_r;
    logic [2:0] smi_sync_r;
    logic nmi_lvl_r;
    logic irq_lvl_r;
    logic smi_lvl_r;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            nmi_sync_r <= 3'h0;
            irq_sync_r <= 3'h0;
            smi_sync_r <= 3'h7;
            nmi_lvl_r <= 1'b0;
            irq_lvl_r <= 1'b0;
            smi_lvl_r <= 1'b1;
        end else begin
            nmi_sync_r <= {nmi_sync_r[1:0], nmi_i};
            irq_sync_r <= {irq_sync_r[1:0], maskable_irq_i};
            smi_sync_r <= {smi_sync_r[1:0], sysmgmt_irq_n_i};
            if (nmi_sync_r[1] == nmi_sync_r[2]) nmi_lvl_r <= nmi_sync_r[2];
            if (irq_sync_r[1] == irq_sync_r[2]) irq_lvl_r <= irq_sync_r[2];
            if (smi_sync_r[1] == smi_sync_r[2]) smi_lvl_r <= smi_sync_r[2];
        end
    end

    logic nmi_prev_r;
    logic nmi_rise;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) nmi_prev_r <= 1'b0;
        else nmi_prev_r <= nmi_lvl_r;
    end
    assign nmi_rise = nmi_lvl_r & ~nmi_prev_r;

    // registers
    logic [31:0] config_control_7_r;
    logic [31:0] tbl_base_r;
    logic [15:0] tbl_limit_r;
    logic [7:0] last_vec_r;
    logic nmi_enabled;
    assign nmi_enabled = config_control_7_r[CONFIG_CONTROL_7_NMI_EN_BIT];

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            config_control_7_r <= CONFIG_CONTROL_7_RST;
            tbl_base_r <= TABLE_BASE_RST;
            tbl_limit_r <= TABLE_LIMIT_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == REG_CONFIG_CONTROL_7) config_control_7_r <= reg_wdata_i;
            if (reg_addr_i == REG_TBL_BASE) tbl_base_r <= reg_wdata_i;
            if (reg_addr_i == REG_TBL_LIMIT) tbl_limit_r <= reg_wdata_i[15:0];
        end
    end

    // nmi pending and blocking state
    logic nmi_pend_r;
    logic in_nmi_r;
    logic halted_r;
    logic halt_in_nmi_r;
    logic irq_ok;
    logic take_smi;
    logic take_nmi;
    logic take_irq;
    logic ack_wait_r;

    // smi is active low; taken at boundary ahead of everything else except an acknowledge already in progress
    assign take_smi = instr_boundary_i & ~smi_lvl_r & ~ack_wait_r;
    assign irq_ok = irq_lvl_r & flags_register_i[FLAG_IE_BIT];
    // nmi is served only at a boundary and only outside an nmi handler
    assign take_nmi = instr_boundary_i & nmi_pend_r & ~in_nmi_r & nmi_enabled
                      & ~take_smi & ~ack_wait_r;
    assign take_irq = (instr_boundary_i | string_point_i) & irq_ok & ~take_smi
                      & ~take_nmi & ~ack_wait_r;

    // one edge latched while blocked; a new edge wins over clearing on take
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) nmi_pend_r <= 1'b0;
        else if (nmi_rise) nmi_pend_r <= 1'b1;
        else if (take_nmi) nmi_pend_r <= 1'b0;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) in_nmi_r <= 1'b0;
        else if (take_nmi) in_nmi_r <= 1'b1;
        else if (return_from_interrupt_i) in_nmi_r <= 1'b0;
    end

    // halt wake: inside nmi handler an nmi edge does not wake the core
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            halted_r <= 1'b0;
            halt_in_nmi_r <= 1'b0;
        end else if (halt_i) begin
            halted_r <= 1'b1;
            halt_in_nmi_r <= in_nmi_r;
        end else if (halted_r && (irq_ok || !smi_lvl_r ||
                     (!halt_in_nmi_r && nmi_pend_r && nmi_enabled))) begin
            halted_r <= 1'b0;
        end
    end

    // acknowledge cycle runs only for maskable interrupts
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) ack_wait_r <= 1'b0;
        else if (take_irq) ack_wait_r <= 1'b1;
        else if (ack_valid_i) ack_wait_r <= 1'b0;
    end
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) ack_cycle_o <= 1'b0;
        else ack_cycle_o <= take_irq;
    end

    // exception selection: highest priority first
    logic exc_any;
    logic [7:0] exc_vec;
    ciex_class_t exc_class;
    logic exc_restart;
    always_comb begin
        exc_any = 1'b1;
        exc_vec = VEC_DEBUG;
        exc_class = CIEX_TRAP;
        exc_restart = 1'b0;
        if (double_fault_i) begin
            exc_vec = VEC_DOUBLE_FAULT;
            exc_class = CIEX_ABORT;
        end else if (data_break_i || (instr_boundary_i && flags_register_i[FLAG_TRACE_BIT])) begin
            exc_vec = VEC_DEBUG;
            exc_class = CIEX_TRAP;
        end else if (instr_break_i) begin
            exc_vec = VEC_DEBUG;
            exc_class = CIEX_FAULT;
            exc_restart = 1'b1;
        end else if (illegal_op_i) begin
            exc_vec = VEC_INVALID_OP;
            exc_class = CIEX_FAULT;
            exc_restart = 1'b1;
        end else if (fault_i) begin
            exc_vec = fault_vector_i;
            exc_class = CIEX_FAULT;
            exc_restart = 1'b1;
        end else if (breakpoint_instr_i) begin
            exc_vec = VEC_BREAKPOINT;
        end else if (soft_interrupt_instr_i) begin
            exc_vec = soft_vector_i;
        end else begin
            exc_any = 1'b0;
        end
    end

    function automatic logic [31:0] entry_addr(input logic [31:0] base, input logic [7:0] vec,
                                               input logic prot);
        logic [31:0] sz;
        sz = prot ? ENTRY_PROT_BYTES : ENTRY_REAL_BYTES;
        entry_addr = base + {24'h0, vec} * sz;
    endfunction : entry_addr

    logic dispatch;
    logic [7:0] disp_vec;
    assign dispatch = (~take_smi & exc_any) | take_nmi | (ack_wait_r & ack_valid_i);
    assign disp_vec = (ack_wait_r & ack_valid_i) ? ack_vector_i :
                      (take_nmi ? VEC_NMI : exc_vec);

    // handler entry outputs and pushed state
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            entry_o <= 1'b0;
            entry_vector_o <= 8'h00;
            entry_class_o <= CIEX_TRAP;
            entry_addr_o <= 32'h0000_0000;
            push_ptr_o <= 32'h0000_0000;
            push_flags_o <= 32'h0000_0000;
            push_error_o <= 16'h0000;
            push_error_valid_o <= 1'b0;
            sysmgmt_entry_o <= 1'b0;
            last_vec_r <= 8'h00;
        end else begin
            entry_o <= dispatch;
            sysmgmt_entry_o <= take_smi;
            if (dispatch) begin
                entry_vector_o <= disp_vec;
                last_vec_r <= disp_vec;
                entry_addr_o <= entry_addr(tbl_base_r, disp_vec, protected_mode_i);
                entry_class_o <= (exc_any && !take_nmi && !ack_wait_r) ? exc_class : CIEX_MASKABLE_IRQ;
                // faults restart at the faulting instruction, others resume after
                // hardware interrupts and traps resume at the next instruction
                push_ptr_o <= (exc_any && exc_restart && !take_nmi && !ack_wait_r) ?
                              instr_ptr_i : next_ptr_i;
                push_flags_o <= flags_register_i;
                push_error_o <= error_code_i;
                push_error_valid_o <= protected_mode_i & error_code_valid_i;
            end
        end
    end

    // interrupt gate flagged in status bit 4 with the entry; the flags image handed to the handler is unchanged
    logic ie_clear_r;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) ie_clear_r <= 1'b0;
        else ie_clear_r <= dispatch & gate_is_maskable_irq_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            halted_o <= 1'b0;
            in_nmi_o <= 1'b0;
        end else begin
            halted_o <= halted_r;
            in_nmi_o <= in_nmi_r;
        end
    end

    // read port, data one cycle after strobe; unmapped reads return zero
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) reg_rdata_o <= 32'h0000_0000;
        else if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_CONFIG_CONTROL_7: reg_rdata_o <= config_control_7_r;
                REG_TBL_BASE: reg_rdata_o <= tbl_base_r;
                REG_TBL_LIMIT: reg_rdata_o <= {16'h0000, tbl_limit_r};
                REG_STATUS: reg_rdata_o <= {27'h0, ie_clear_r, ack_wait_r, halted_r,
                                            nmi_pend_r, in_nmi_r};
                REG_LAST_VEC: reg_rdata_o <= {24'h0, last_vec_r};
                default: reg_rdata_o <= 32'h0000_0000;
            endcase
        end else reg_rdata_o <= 32'h0000_0000;
    end

    // checks
    nmi_vector_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take_nmi |=> entry_o && entry_vector_o == 8'h02)
        else $error("nmi not dispatched on vector 2");
    nmi_no_ack_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take_nmi |=> !ack_cycle_o)
        else $error("acknowledge cycle for nmi");
    smi_first_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take_smi |-> !take_nmi && !take_irq)
        else $error("smi did not win");
    nmi_block_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        in_nmi_r |-> !take_nmi)
        else $error("nested nmi taken");
    irq_mask_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take_irq |-> flags_register_i[9])
        else $error("irq taken while masked");
    irq_ack_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take_irq |=> ack_cycle_o ##0 ack_wait_r)
        else $error("no acknowledge cycle");
    trace_vec_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (instr_boundary_i && flags_register_i[8] && !double_fault_i && !take_smi && !take_nmi
         && !(ack_wait_r && ack_valid_i)) |=> entry_vector_o == 8'h01)
        else $error("trace did not raise vector 1");
    abort_cls_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (double_fault_i && !take_smi && !take_nmi && !ack_wait_r)
        |=> entry_class_o == CIEX_ABORT && entry_vector_o == 8'h08)
        else $error("double fault not abort");
    table_rst_a: assert property (@(posedge sys_clk_i)
        $past(sys_rst_i) && !sys_rst_i |-> tbl_base_r == 32'h0 && tbl_limit_r == 16'h03FF)
        else $error("table register reset wrong");
    // vector answer from the controller, then an interrupt-class entry
    sequence ack_seen_s;
        ack_wait_r && ack_valid_i;
    endsequence
    sequence entry_int_s;
        entry_o && entry_class_o == CIEX_MASKABLE_IRQ;
    endsequence
    ack_entry_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_seen_s |=> entry_int_s ##0 push_ptr_o == $past(next_ptr_i))
        else $error("acknowledged vector not entered");
    irq_point_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take_irq |-> instr_boundary_i || string_point_i)
        else $error("irq taken off an interrupt point");
    halt_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        halted_r && halt_in_nmi_r && !halt_i && !irq_ok && smi_lvl_r |=> halted_r)
        else $error("halt in nmi handler left without a wake source");
    soft_int_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        soft_interrupt_instr_i && !flags_register_i[9] && !take_smi |=> entry_o)
        else $error("soft interrupt dropped while masked");
    push_flags_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        entry_o |-> push_flags_o == $past(flags_register_i))
        else $error("pushed flags wrong");
    entry_addr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        entry_o |-> entry_addr_o == $past(tbl_base_r) + {24'h0, entry_vector_o}
            * ($past(protected_mode_i) ? 32'h0000_0008 : 32'h0000_0004))
        else $error("table entry address wrong");
    trap_ptr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        entry_o && entry_class_o == CIEX_TRAP |-> push_ptr_o == $past(next_ptr_i))
        else $error("trap saved the wrong pointer");
    fault_ptr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        entry_o && entry_class_o == CIEX_FAULT |-> push_ptr_o == $past(instr_ptr_i))
        else $error("fault saved the wrong pointer");
endmodule : ciex_unit
`default_nettype wire

// File: verif/ciex_pic_model.sv
`timescale 1ns/1ps
`default_nettype none
module ciex_pic_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // acknowledge cycle from the unit
    input wire logic ack_cycle_i,
    input wire logic [7:0] vector_i,
    input wire logic [3:0] delay_i,
    output logic ack_valid_o,
    output logic [7:0] ack_vector_o
);
    logic [4:0] cnt_r;
    logic [7:0] last_r;
    // answer each acknowledge cycle after delay_i plus one idle cycles with one vector
    always_ff @(posedge clk_i) begin
        ack_valid_o <= 1'b0;
        ack_vector_o <= ~last_r; // released vector bus never shows a stale value
        if (rst_i) begin
            cnt_r <= 5'h00;
            last_r <= 8'h00;
        end else if (ack_cycle_i) begin
            cnt_r <= {1'b0, delay_i} + 5'h01;
        end else if (cnt_r == 5'h01) begin
            ack_valid_o <= 1'b1;
            ack_vector_o <= vector_i; // vector_i kept in 32 to 255
            last_r <= vector_i;
            cnt_r <= 5'h00;
        end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
        end
    end
endmodule : ciex_pic_model
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ciex_pkg::*;
    // clock, reset, pins and pipeline events
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1;
    logic nmi_i = 1'b0, maskable_irq_i = 1'b0, sysmgmt_irq_n_i = 1'b1;
    logic ack_cycle_o, ack_valid_i, sysmgmt_entry_o, halted_o, in_nmi_o, entry_o;
    logic [7:0] ack_vector_i, entry_vector_o, pic_vec = 8'h40;
    logic [3:0] pic_delay = 4'h3;
    logic instr_boundary_i = 1'b1, string_point_i = 1'b0, protected_mode_i = 1'b0;
    logic [31:0] instr_ptr_i = 32'h0000_1000, next_ptr_i = 32'h0000_1003;
    logic [31:0] flags_register_i = 32'h0, tbl_base = 32'h0;
    logic halt_i = 1'b0, return_from_interrupt_i = 1'b0, soft_interrupt_instr_i = 1'b0;
    logic breakpoint_instr_i = 1'b0, data_break_i = 1'b0, instr_break_i = 1'b0;
    logic illegal_op_i = 1'b0, fault_i = 1'b0, double_fault_i = 1'b0;
    logic [7:0] soft_vector_i = 8'h81, fault_vector_i = 8'h0D;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, entry_addr_o, push_ptr_o, push_flags_o;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, push_error_valid_o;
    logic [15:0] push_error_o;
    ciex_class_t entry_class_o;
    int fail_count = 0, compares = 0, ack_n = 0, a0;
    logic [7:0] vt [8] = '{VEC_BREAKPOINT, VEC_INVALID_OP, VEC_DOUBLE_FAULT, VEC_DEBUG,
                           VEC_DEBUG, 8'h81, VEC_DEBUG, 8'h0D};
    ciex_class_t ct [8] = '{CIEX_TRAP, CIEX_FAULT, CIEX_ABORT, CIEX_TRAP,
                            CIEX_FAULT, CIEX_TRAP, CIEX_TRAP, CIEX_FAULT};
    // clock at 125 MHz and acknowledge counter
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (ack_cycle_o === 1'b1) ack_n++;
    ciex_unit dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .nmi_i(nmi_i),
        .maskable_irq_i(maskable_irq_i), .sysmgmt_irq_n_i(sysmgmt_irq_n_i),
        .ack_cycle_o(ack_cycle_o), .ack_valid_i(ack_valid_i), .ack_vector_i(ack_vector_i),
        .instr_boundary_i(instr_boundary_i), .string_point_i(string_point_i),
        .instr_ptr_i(instr_ptr_i), .next_ptr_i(next_ptr_i),
        .flags_register_i(flags_register_i), .protected_mode_i(protected_mode_i),
        .halt_i(halt_i), .return_from_interrupt_i(return_from_interrupt_i),
        .soft_interrupt_instr_i(soft_interrupt_instr_i),
        .breakpoint_instr_i(breakpoint_instr_i), .soft_vector_i(soft_vector_i),
        .data_break_i(data_break_i), .instr_break_i(instr_break_i),
        .illegal_op_i(illegal_op_i), .fault_i(fault_i), .fault_vector_i(fault_vector_i),
        .double_fault_i(double_fault_i), .gate_is_maskable_irq_i(1'b1), .error_code_i(16'h0000),
        .error_code_valid_i(1'b0), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .entry_o(entry_o), .entry_vector_o(entry_vector_o), .entry_class_o(entry_class_o),
        .entry_addr_o(entry_addr_o), .push_ptr_o(push_ptr_o), .push_flags_o(push_flags_o),
        .push_error_o(push_error_o), .push_error_valid_o(push_error_valid_o),
        .sysmgmt_entry_o(sysmgmt_entry_o), .halted_o(halted_o), .in_nmi_o(in_nmi_o));
    ciex_pic_model pic (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .ack_cycle_i(ack_cycle_o),
        .vector_i(pic_vec), .delay_i(pic_delay), .ack_valid_o(ack_valid_i),
        .ack_vector_o(ack_vector_i));
    // verdict in one place
    task wrap_up;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : check
    // bounded wait: 0 entry, 1 acknowledge, 2 sysmgmt entry; running out ends the run
    task automatic wait_sig(input int which);
        bit seen;
        seen = 1'b0;
        for (int i = 0; i < 16 && !seen; i++) begin
            @(negedge sys_clk_i);
            seen = (which == 0) ? (entry_o === 1'b1) :
                   (which == 1) ? (ack_cycle_o === 1'b1) : (sysmgmt_entry_o === 1'b1);
        end
        if (!seen) begin
            fail_count++;
            $display("CHECK FAILED at %0t: wait %0d ran out", $time, which);
            wrap_up();
        end
    endtask : wait_sig
    // count entry pulses over a quiet window
    task automatic no_entry(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(negedge sys_clk_i);
            if (entry_o !== 1'b0) hits++;
        end
        check(hits, 0, "unexpected entry");
    endtask : no_entry
    task automatic expect_entry(input logic [7:0] vec, input logic [31:0] ptr);
        wait_sig(0);
        check(entry_vector_o, vec, "entry vector");
        check(push_ptr_o, ptr, "pushed pointer");
        check(entry_addr_o, tbl_base + vec * 4, "entry address");
    endtask : expect_entry
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        check(reg_rdata_o, exp, "register read");
    endtask : reg_rd_chk
    // one cycle exception request with the expected class and pointer
    task automatic exc(input int k, input logic [31:0] size);
        @(posedge sys_clk_i);
        case (k)
            0: breakpoint_instr_i <= 1'b1;
            1: illegal_op_i <= 1'b1;
            2: double_fault_i <= 1'b1;
            3: data_break_i <= 1'b1;
            4: instr_break_i <= 1'b1;
            5: soft_interrupt_instr_i <= 1'b1;
            6: flags_register_i <= 32'h0000_0100;
            default: fault_i <= 1'b1;
        endcase
        @(posedge sys_clk_i);
        {breakpoint_instr_i, illegal_op_i, double_fault_i, data_break_i} <= 4'h0;
        {instr_break_i, soft_interrupt_instr_i, fault_i} <= 3'h0;
        flags_register_i <= 32'h0;
        wait_sig(0);
        check(entry_vector_o, vt[k], "exception vector");
        check(32'(entry_class_o), 32'(ct[k]), "exception class");
        check(entry_addr_o, tbl_base + vt[k] * size, "table entry");
        if (ct[k] != CIEX_ABORT)
            check(push_ptr_o, (ct[k] == CIEX_TRAP) ? next_ptr_i : instr_ptr_i,
                  "saved pointer");
    endtask : exc
    initial begin
        repeat (6) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge sys_clk_i);
        check(entry_o, 1'b0, "entry idle after reset");
        reg_rd_chk(REG_TBL_BASE, 32'h0000_0000);
        reg_rd_chk(REG_TBL_LIMIT, 32'h0000_03FF);
        reg_rd_chk(REG_CONFIG_CONTROL_7, 32'h0000_0000);
        reg_wr(8'h40, 32'hFFFF_FFFF);
        reg_rd_chk(8'h40, 32'h0000_0000);
        // every exception source in real mode, then in protected mode at a moved base
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                tbl_base = 32'h0000_2000;
                reg_wr(REG_TBL_BASE, tbl_base);
                reg_rd_chk(REG_TBL_BASE, 32'h0000_2000);
                protected_mode_i <= 1'b1;
            end
            for (int k = 0; k < 8; k++) exc(k, p ? 32'h8 : 32'h4);
        end
        protected_mode_i <= 1'b0;
        // masked request, then no interrupt point, then a string move point
        maskable_irq_i <= 1'b1;
        no_entry(12);
        check(ack_n, 0, "ack while masked");
        instr_boundary_i <= 1'b0;
        flags_register_i <= 32'h0000_0200;
        no_entry(12);
        check(ack_n, 0, "ack off boundary");
        string_point_i <= 1'b1;
        wait_sig(1);
        {maskable_irq_i, string_point_i, instr_boundary_i} <= 3'b001;
        expect_entry(8'h40, next_ptr_i);
        check(32'(entry_class_o), 32'(CIEX_MASKABLE_IRQ), "irq class");
        check(push_flags_o, 32'h0000_0200, "pushed flags");
        flags_register_i <= 32'h0;
        // nmi held off until enabled, then fixed vector without acknowledge
        nmi_i <= 1'b1;
        no_entry(12);
        a0 = ack_n;
        reg_wr(REG_CONFIG_CONTROL_7, 32'h0000_0004);
        expect_entry(VEC_NMI, next_ptr_i);
        check(ack_n, a0, "ack for nmi");
        @(negedge sys_clk_i);
        check(in_nmi_o, 1'b1, "in nmi");
        nmi_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        nmi_i <= 1'b1;
        no_entry(12);
        @(posedge sys_clk_i);
        return_from_interrupt_i <= 1'b1;
        @(posedge sys_clk_i);
        return_from_interrupt_i <= 1'b0;
        expect_entry(VEC_NMI, next_ptr_i);
        // halt inside the nmi handler: a new nmi edge must not wake it
        nmi_i <= 1'b0;
        halt_i <= 1'b1;
        @(posedge sys_clk_i);
        halt_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        nmi_i <= 1'b1;
        no_entry(12);
        check(halted_o, 1'b1, "halt kept on nmi");
        pic_vec <= 8'hC5;
        pic_delay <= 4'h0;
        flags_register_i <= 32'h0000_0200;
        maskable_irq_i <= 1'b1;
        wait_sig(1);
        maskable_irq_i <= 1'b0;
        flags_register_i <= 32'h0;
        expect_entry(8'hC5, next_ptr_i);
        @(negedge sys_clk_i);
        check(halted_o, 1'b0, "woken by irq");
        // system management request beats a pending maskable request
        a0 = ack_n;
        flags_register_i <= 32'h0000_0200;
        {maskable_irq_i, sysmgmt_irq_n_i} <= 2'b10;
        wait_sig(2);
        check(ack_n, a0, "irq before smi");
        {maskable_irq_i, sysmgmt_irq_n_i} <= 2'b01;
        flags_register_i <= 32'h0;
        repeat (10) @(posedge sys_clk_i);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
